// file: aio_digital_io_tb.sv
// self-checking bench for the auxiliary digital i/o block over apb
// assumes the field model resolves lines and zero-wait apb answers
`timescale 1ns/100ps
module aio_top_tb;
  logic pclk = 1'b0; // 25 MHz bus clock
  logic presetn = 1'b0; // active-low reset
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] gpio_in;
  logic [23:0] gpio_out;
  logic [23:0] gpio_oe_n;
  logic [23:0] field_drv = 24'h005AC3; // rack levels: port1 C3, port2 5A
  int n_mismatch = 0;
  int num_checks = 0;
  int hi;
  logic [31:0] rd;
  logic err;

  always #20 pclk = ~pclk;

  aio_top i_aio_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n));
  aio_field_model i_aio_field_model (.field_drv(field_drv), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; waits for pready without assuming a latency
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
           output logic [31:0] rdv, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a transfer that never completes
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h00000000, rd, err);
    check(name, rd, exp);
  endtask

  // counts high samples of one pin over a window of pclk cycles
  task count_high(input int line, input int cycles);
    hi = 0;
    repeat (cycles)
    begin
      @(posedge pclk);
      if (gpio_out[line] === 1'b1) hi++;
    end
  endtask

  task print_verdict;
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    print_verdict;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check("oe_rst", {8'h00, gpio_oe_n}, 32'h0000FFFF);
    check("out_rst", {8'h00, gpio_out}, 32'h00000000);
    rd_chk(aio_pkg::ADDR_DIR, 32'h00000000, "dir_rst");
    rd_chk(aio_pkg::ADDR_POL, 32'h00000000, "pol_rst");
    rd_chk(aio_pkg::ADDR_ALT, 32'h00000000, "alt_rst");
    rd_chk(aio_pkg::ADDR_DATA, 32'h00005AC3, "in_read");
    wr(aio_pkg::ADDR_POL, 32'h000000FF);
    rd_chk(aio_pkg::ADDR_DATA, 32'h00005A3C, "in_inv");
    // writes to lines that are inputs must leave their latches alone
    wr(aio_pkg::ADDR_DATA, 32'h00FFFFFF);
    rd_chk(aio_pkg::ADDR_DATA, 32'h00FF5A3C, "wr_inputs");
    repeat (2) @(posedge pclk);
    check("p3_pins", {8'h00, gpio_out & ~gpio_oe_n}, 32'h00FF0000);
    wr(aio_pkg::ADDR_DIR, 32'h00000003);
    repeat (2) @(posedge pclk);
    check("oe_out", {8'h00, gpio_oe_n}, 32'h00001800);
    rd_chk(aio_pkg::ADDR_DATA, 32'h00FF1800, "latch_kept");
    wr(aio_pkg::ADDR_DATA, 32'h00123456);
    rd_chk(aio_pkg::ADDR_DATA, 32'h00123C56, "out_read");
    repeat (2) @(posedge pclk);
    check("out_pins", {8'h00, gpio_out & ~gpio_oe_n}, 32'h001224A9);
    // masked updates: port1, port3 with on and off on one bit, no-op port
    wr(aio_pkg::ADDR_MSC, 32'h00000681);
    wr(aio_pkg::ADDR_MSC, 32'h00020101);
    wr(aio_pkg::ADDR_MSC, 32'h0003FFFF);
    rd_chk(aio_pkg::ADDR_DATA, 32'h00133CD1, "masked");
    rd_chk(aio_pkg::ADDR_MSC, 32'h00000000, "msc_rd");
    rd_chk(aio_pkg::ADDR_PIN, 32'h00133C2E, "raw_pins");
    rd_chk(8'h28, 32'h00000000, "unmapped");
    check("unmapped_err", {31'h0, err}, 32'h00000001);
    // both generators on the internal clock; port3 latch bits 0,1 are 1
    wr(aio_pkg::ADDR_POL, 32'h00000000);
    wr(aio_pkg::ADDR_PA_PER, 32'h00000004);
    wr(aio_pkg::ADDR_PA_DUTY, 32'h00000001);
    wr(aio_pkg::ADDR_PB_PER, 32'h00000005);
    wr(aio_pkg::ADDR_PB_DUTY, 32'h00000003);
    wr(aio_pkg::ADDR_ALT, 32'h00000006);
    repeat (10) @(posedge pclk);
    count_high(aio_pkg::PA_LINE, 40);
    check("pa_high", 32'(hi), 32'd10);
    count_high(aio_pkg::PB_LINE, 40);
    check("pb_high", 32'(hi), 32'd24);
    wr(aio_pkg::ADDR_POL, 32'h00020000);
    repeat (5) @(posedge pclk);
    count_high(aio_pkg::PB_LINE, 40);
    check("pb_inv", 32'(hi), 32'd16);
    wr(aio_pkg::ADDR_PA_DUTY, 32'h00000004);
    repeat (10) @(posedge pclk);
    count_high(aio_pkg::PA_LINE, 40);
    check("pa_full", 32'(hi), 32'd40);
    wr(aio_pkg::ADDR_PA_DUTY, 32'h00000000);
    repeat (3) @(posedge pclk);
    count_high(aio_pkg::PA_LINE, 20);
    check("pa_zero", 32'(hi), 32'd0);
    // external clock: no edges means a frozen output
    wr(aio_pkg::ADDR_PA_DUTY, 32'h00000001);
    field_drv[aio_pkg::ECLK_LINE] <= 1'b0;
    wr(aio_pkg::ADDR_ALT, 32'h0000000B);
    repeat (10) @(posedge pclk);
    count_high(aio_pkg::PA_LINE, 20);
    check("eclk_idle", 32'(hi == 0 || hi == 20), 32'd1);
    // one rising edge every 8 cycles gives a 32-cycle output period
    fork
      repeat (12)
      begin
        field_drv[aio_pkg::ECLK_LINE] <= 1'b1;
        repeat (4) @(posedge pclk);
        field_drv[aio_pkg::ECLK_LINE] <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      begin
        repeat (24) @(posedge pclk);
        count_high(aio_pkg::PA_LINE, 64);
      end
    join
    check("eclk_run", 32'(hi), 32'd16);
    print_verdict;
  end
endmodule

// file: aio_field_model.sv
// field side of the auxiliary i/o lines: conditioning rack and field devices
// assumes the pad drives a line from gpio_out while its gpio_oe_n is low
`timescale 1ns/100ps
module aio_field_model
(
  input wire logic [23:0] field_drv,
  input wire logic [23:0] gpio_out,
  input wire logic [23:0] gpio_oe_n,
  output logic [23:0] gpio_in
);
  // ----------------------------------------------------------------
  // line resolution
  // ----------------------------------------------------------------
  // a driven line shows the block's own level; the rack drives every
  // other line, so no input is left for the simulator to settle
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      gpio_in[i] = gpio_oe_n[i] ? field_drv[i] : gpio_out[i];
    end
  end
endmodule

// file: aio_pkg.sv
// constants shared by the auxiliary digital i/o block and its helpers
// assumes a 32-bit apb slave with byte addresses in the low eight bits
package aio_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_DIR = 8'h00;     // port direction settings
  localparam logic [7:0] ADDR_POL = 8'h04;     // per-line polarity
  localparam logic [7:0] ADDR_DATA = 8'h08;    // logical port data, full-port write
  localparam logic [7:0] ADDR_MSC = 8'h0C;     // masked set/clear write
  localparam logic [7:0] ADDR_ALT = 8'h10;     // alternate function select
  localparam logic [7:0] ADDR_PA_PER = 8'h14;  // pulse_out_a period
  localparam logic [7:0] ADDR_PA_DUTY = 8'h18; // pulse_out_a duty
  localparam logic [7:0] ADDR_PB_PER = 8'h1C;  // pulse_out_b period
  localparam logic [7:0] ADDR_PB_DUTY = 8'h20; // pulse_out_b duty
  localparam logic [7:0] ADDR_PIN = 8'h24;     // raw synchronised pin levels

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int DIR_P1_BIT = 0;    // 1 = first port drives
  localparam int DIR_P2_BIT = 1;    // 1 = second port drives
  localparam int ALT_ECLK_BIT = 0;  // second port bit 3 becomes clock input
  localparam int ALT_PA_BIT = 1;    // third port bit 0 becomes pulse_out_a
  localparam int ALT_PB_BIT = 2;    // third port bit 1 becomes pulse_out_b
  localparam int ALT_CSEL_BIT = 3;  // 1 = generators count external clock
  localparam int MSC_ON_LSB = 0;    // force_on_mask byte
  localparam int MSC_OFF_LSB = 8;   // force_off_mask byte
  localparam int MSC_PORT_LSB = 16; // two-bit port select
  localparam int ECLK_LINE = 11;    // second port bit 3
  localparam int PA_LINE = 16;      // third port bit 0
  localparam int PB_LINE = 17;      // third port bit 1

  // ------------------------------------------------------------
  // line masks and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] P2_OUT_MASK = 8'hE7; // bits 3 and 4 never drive
  localparam logic [1:0] RST_DIR = 2'h0;
  localparam logic [23:0] RST_POL = 24'h000000;
  localparam logic [3:0] RST_ALT = 4'h0;
  localparam logic [23:0] RST_OUT = 24'h000000;
  localparam logic [15:0] RST_PER = 16'h0000;
  localparam logic [15:0] RST_DUTY = 16'h0000;
  localparam logic [23:0] RST_OE_N = 24'h00FFFF; // third port driven, first two inputs

endpackage

// file: aio_pwm.sv
// one pulse width generator counting ticks over a programmed period
// assumes tick is a single-cycle strobe on pclk
`timescale 1ns/100ps
module aio_pwm #(parameter int WIDTH = 16)
(
  input wire logic pclk,
  input wire logic presetn,
  aio_pwm_if.gen pw
);

  logic [WIDTH-1:0] cnt;      // position inside the period
  logic [WIDTH-1:0] next_cnt;
  logic next_level;

  // ------------------------------------------------------------
  // counter and compare
  // ------------------------------------------------------------
  always_comb
  begin
    next_cnt = cnt;
    next_level = pw.level;
    if (!pw.en || pw.period == '0)
    begin
      // idle: a zero period would never wrap, so hold inactive
      next_cnt = '0;
      next_level = 1'b0;
    end
    else
    begin
      // the count steps only on a tick, wrapping at the period
      if (pw.tick)
      begin
        if (cnt >= WIDTH'(pw.period - 1'b1))
          next_cnt = '0;
        else
          next_cnt = WIDTH'(cnt + 1'b1);
      end
      // compared every cycle, so a new duty shows even with no ticks
      next_level = (next_cnt < pw.duty);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
      pw.level <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      pw.level <= next_level;
    end
  end

endmodule

// file: aio_pwm_if.sv
// control bundle between the i/o top and one pulse width generator
// assumes both ends run on the same pclk
`timescale 1ns/100ps
interface aio_pwm_if #(parameter int WIDTH = 16);
  logic tick;               // one count step
  logic en;                 // generator enabled
  logic [WIDTH-1:0] period; // ticks per cycle
  logic [WIDTH-1:0] duty;   // active ticks per cycle
  logic level;              // logical output level
  modport ctrl (output tick, output en, output period, output duty, input level);
  modport gen (input tick, input en, input period, input duty, output level);
endinterface

// file: aio_sync.sv
// two-stage synchroniser for pin levels
// assumes the inputs are asynchronous to pclk
`timescale 1ns/100ps
module aio_sync #(parameter int WIDTH = 24)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta; // first stage, read only by q

  // ------------------------------------------------------------
  // both stages
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// file: aio_top.sv
// auxiliary 24-line digital i/o with two pulse width outputs, apb slave
// assumes pins are asynchronous; the pad ring resolves gpio_out/gpio_oe_n
//
// Operation
// - three byte-wide ports, one bit per line
// - first port has one direction for all bits
// - second port bits 3,4 always inputs
// - third port is output only
// - polarity selectable for every line
// - software sees logical values, pins see polarity
// - input reads return polarity-corrected pin value
// - writes to input bits are ignored
// - output bits read back last written value
// - force-on and force-off masked update
// - full-port write sets all output bits
// - second port bit 3 may be clock input
// - third port bits 0,1 may be pulse outputs
// - alternate-function bits leave general-purpose use
// - two pulse generators, independent period and duty
// - generators count internal or external clock
// - polarity applies to alternate functions too
`timescale 1ns/100ps
module aio_top #(parameter int PWM_W = 16)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] gpio_in,
  output logic [23:0] gpio_out,
  output logic [23:0] gpio_oe_n
);

  // ------------------------------------------------------------
  // state and nets
  // ------------------------------------------------------------
  logic [1:0] dir;               // direction of first and second port
  logic [23:0] pol;              // 1 = active-low line
  logic [3:0] alt;               // alternate function selects
  logic [23:0] out_lat;          // logical output latch
  logic [PWM_W-1:0] pa_per, pa_duty, pb_per, pb_duty;
  logic eclk_prev;               // last logical external clock level
  logic [1:0] next_dir;
  logic [23:0] next_pol, next_out_lat, next_gpio_out, next_gpio_oe_n;
  logic [3:0] next_alt;
  logic [PWM_W-1:0] next_pa_per, next_pa_duty, next_pb_per, next_pb_duty;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [23:0] pin_sync;         // synchronised pin levels
  logic [23:0] in_log;           // logical pin values
  logic [23:0] drive_mask;       // lines the block drives
  logic [23:0] wr_mask;          // lines that accept write data
  logic [23:0] pwm_mask;         // lines taken by pulse outputs
  logic [23:0] pwm_vec;          // pulse levels placed on their lines
  logic [23:0] data_view;        // logical port data seen by reads
  logic [23:0] msc_on, msc_off;  // masks moved to the selected port
  logic ext_tick;
  logic setup, wr_acc;

  aio_pwm_if #(.WIDTH(PWM_W)) pa_if ();
  aio_pwm_if #(.WIDTH(PWM_W)) pb_if ();

  // ------------------------------------------------------------
  // pin synchroniser and generators
  // ------------------------------------------------------------
  aio_sync #(.WIDTH(24)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(gpio_in),
    .q(pin_sync)
  );

  aio_pwm #(.WIDTH(PWM_W)) u_pwm_a (
    .pclk(pclk),
    .presetn(presetn),
    .pw(pa_if.gen)
  );

  aio_pwm #(.WIDTH(PWM_W)) u_pwm_b (
    .pclk(pclk),
    .presetn(presetn),
    .pw(pb_if.gen)
  );

  // ------------------------------------------------------------
  // line classification and generator feeds
  // ------------------------------------------------------------
  // all lines are classified from the settings alone, so a direction
  // or alternate change acts at the very next edge
  always_comb
  begin
    // polarity turns pins into logical values
    in_log = pin_sync ^ pol;
    // third port always drives, second omits bits 3,4
    drive_mask = {8'hFF, dir[aio_pkg::DIR_P2_BIT] ? aio_pkg::P2_OUT_MASK : 8'h00,
                  dir[aio_pkg::DIR_P1_BIT] ? 8'hFF : 8'h00};
    pwm_mask = '0;
    pwm_mask[aio_pkg::PA_LINE] = alt[aio_pkg::ALT_PA_BIT];
    pwm_mask[aio_pkg::PB_LINE] = alt[aio_pkg::ALT_PB_BIT];
    pwm_vec = '0;
    pwm_vec[aio_pkg::PA_LINE] = pa_if.level;
    pwm_vec[aio_pkg::PB_LINE] = pb_if.level;
    // pulse lines take no general-purpose writes
    wr_mask = drive_mask & ~pwm_mask;
    // inputs read the pin, outputs the latch; clock line reads zero
    data_view = (in_log & ~drive_mask) | (out_lat & wr_mask) | (pwm_vec & pwm_mask);
    data_view[aio_pkg::ECLK_LINE] = in_log[aio_pkg::ECLK_LINE] & ~alt[aio_pkg::ALT_ECLK_BIT];
    // external clock counts on logical rising edges, polarity included
    ext_tick = alt[aio_pkg::ALT_ECLK_BIT] & in_log[aio_pkg::ECLK_LINE] & ~eclk_prev;
    // clock source choice
    pa_if.tick = alt[aio_pkg::ALT_CSEL_BIT] ? ext_tick : 1'b1;
    pb_if.tick = pa_if.tick;
    // independent settings per generator
    pa_if.en = alt[aio_pkg::ALT_PA_BIT];
    pa_if.period = pa_per;
    pa_if.duty = pa_duty;
    pb_if.en = alt[aio_pkg::ALT_PB_BIT];
    pb_if.period = pb_per;
    pb_if.duty = pb_duty;
    // masked update masks moved onto the chosen port; port code 3 hits nothing
    unique case (pwdata[aio_pkg::MSC_PORT_LSB +: 2])
      2'h0:
      begin
        msc_on = {16'h0000, pwdata[aio_pkg::MSC_ON_LSB +: 8]};
        msc_off = {16'h0000, pwdata[aio_pkg::MSC_OFF_LSB +: 8]};
      end
      2'h1:
      begin
        msc_on = {8'h00, pwdata[aio_pkg::MSC_ON_LSB +: 8], 8'h00};
        msc_off = {8'h00, pwdata[aio_pkg::MSC_OFF_LSB +: 8], 8'h00};
      end
      2'h2:
      begin
        msc_on = {pwdata[aio_pkg::MSC_ON_LSB +: 8], 16'h0000};
        msc_off = {pwdata[aio_pkg::MSC_OFF_LSB +: 8], 16'h0000};
      end
      default:
      begin
        msc_on = '0;
        msc_off = '0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // apb decode and register next values
  // ------------------------------------------------------------
  // pready comes from a flop set in the setup cycle, so every transfer
  // ends in its first access cycle; the price is that read data is
  // captured at setup and a pin change in the access cycle is not seen
  always_comb
  begin
    setup = psel & ~penable;
    // writes land only at the completing access edge
    wr_acc = psel & penable & pready & pwrite;
    next_dir = dir;
    next_pol = pol;
    next_alt = alt;
    next_out_lat = out_lat;
    next_pa_per = pa_per;
    next_pa_duty = pa_duty;
    next_pb_per = pb_per;
    next_pb_duty = pb_duty;
    // answer prepared in setup so pready comes from a flop, zero wait
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (setup)
    begin
      next_prdata = '0;
      unique case (paddr)
        aio_pkg::ADDR_DIR: next_prdata = {30'h0, dir};
        aio_pkg::ADDR_POL: next_prdata = {8'h00, pol};
        aio_pkg::ADDR_DATA: next_prdata = {8'h00, data_view};
        aio_pkg::ADDR_MSC: next_prdata = '0;
        aio_pkg::ADDR_ALT: next_prdata = {28'h0, alt};
        aio_pkg::ADDR_PA_PER: next_prdata = 32'(pa_per);
        aio_pkg::ADDR_PA_DUTY: next_prdata = 32'(pa_duty);
        aio_pkg::ADDR_PB_PER: next_prdata = 32'(pb_per);
        aio_pkg::ADDR_PB_DUTY: next_prdata = 32'(pb_duty);
        aio_pkg::ADDR_PIN: next_prdata = {8'h00, pin_sync};
        default: next_pslverr = 1'b1; // unmapped: error, reads zero
      endcase
    end
    if (wr_acc)
    begin
      unique case (paddr)
        aio_pkg::ADDR_DIR: next_dir = pwdata[1:0];
        aio_pkg::ADDR_POL: next_pol = pwdata[23:0];
        // whole-port write, input bits keep their state
        aio_pkg::ADDR_DATA: next_out_lat = (out_lat & ~wr_mask) | (pwdata[23:0] & wr_mask);
        // force-off then force-on, so on wins a clash
        aio_pkg::ADDR_MSC: next_out_lat = (out_lat & ~(msc_off & wr_mask)) | (msc_on & wr_mask);
        aio_pkg::ADDR_ALT: next_alt = pwdata[3:0];
        aio_pkg::ADDR_PA_PER: next_pa_per = pwdata[PWM_W-1:0];
        aio_pkg::ADDR_PA_DUTY: next_pa_duty = pwdata[PWM_W-1:0];
        aio_pkg::ADDR_PB_PER: next_pb_per = pwdata[PWM_W-1:0];
        aio_pkg::ADDR_PB_DUTY: next_pb_duty = pwdata[PWM_W-1:0];
        default: next_dir = dir; // read-only or unmapped: no effect
      endcase
    end
    // pins show logical value through polarity, pulses included
    next_gpio_out = ((out_lat & ~pwm_mask) | (pwm_vec & pwm_mask)) ^ pol;
    // enable low while driving
    next_gpio_oe_n = ~drive_mask;
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // every pad-facing output is a flop, so decode glitches never reach
  // the lines; the cost is one cycle from latch change to pin change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // inputs, active-high, no alternates, outputs inactive
      dir <= aio_pkg::RST_DIR;
      pol <= aio_pkg::RST_POL;
      alt <= aio_pkg::RST_ALT;
      out_lat <= aio_pkg::RST_OUT;
      pa_per <= PWM_W'(aio_pkg::RST_PER);
      pa_duty <= PWM_W'(aio_pkg::RST_DUTY);
      pb_per <= PWM_W'(aio_pkg::RST_PER);
      pb_duty <= PWM_W'(aio_pkg::RST_DUTY);
      eclk_prev <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      gpio_out <= aio_pkg::RST_OUT;
      gpio_oe_n <= aio_pkg::RST_OE_N;
    end
    else
    begin
      dir <= next_dir;
      pol <= next_pol;
      alt <= next_alt;
      out_lat <= next_out_lat;
      pa_per <= next_pa_per;
      pa_duty <= next_pa_duty;
      pb_per <= next_pb_per;
      pb_duty <= next_pb_duty;
      eclk_prev <= in_log[aio_pkg::ECLK_LINE];
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      gpio_out <= next_gpio_out;
      gpio_oe_n <= next_gpio_oe_n;
    end
  end

  // ------------------------------------------------------------
  // assertions and covers
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  port3_drive_a: assert property (gpio_oe_n[23:16] == 8'h00)
    else $error("third port not driven");
  p2_inonly_a: assert property (gpio_oe_n[12:11] == 2'h3)
    else $error("second port bits 3,4 driven");
  p1_group_a: assert property ((gpio_oe_n[7:0] == 8'h00) || (gpio_oe_n[7:0] == 8'hFF))
    else $error("first port split direction");
  in_write_a: assert property ((wr_acc && paddr == aio_pkg::ADDR_DATA && !dir[0])
    |=> $stable(out_lat[7:0]))
    else $error("write changed input latch");
  full_write_a: assert property ((wr_acc && paddr == aio_pkg::ADDR_DATA && dir[0])
    |=> out_lat[7:0] == $past(pwdata[7:0]))
    else $error("full write not stored");
  force_on_a: assert property ((wr_acc && paddr == aio_pkg::ADDR_MSC
    && pwdata[17:16] == 2'h2 && pwdata[0] && pwdata[8] && !alt[1])
    |=> out_lat[16])
    else $error("force on missed");
  read_back_a: assert property ((pready && !pwrite && paddr == aio_pkg::ADDR_DATA && dir[0])
    |-> prdata[7:0] == out_lat[7:0])
    else $error("read of outputs wrong");
  pin_level_a: assert property (##1 gpio_out[23:18] == $past(out_lat[23:18] ^ pol[23:18]))
    else $error("pin level not polarity mapped");
  pulse_pin_a: assert property (alt[1] |=> gpio_out[16] == $past(pa_if.level ^ pol[16]))
    else $error("pulse_out_a not on pin");
  zero_duty_a: assert property ((pa_if.en && pa_duty == '0) [*2] |-> !pa_if.level)
    else $error("pulse active at zero duty");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");

  full_write_c: cover property (wr_acc && paddr == aio_pkg::ADDR_DATA);
  msc_write_c: cover property (wr_acc && paddr == aio_pkg::ADDR_MSC);
  pulse_rise_c: cover property (pa_if.en ##1 $rose(pa_if.level));
  ext_tick_c: cover property (ext_tick && alt[3]);
  zero_duty_c: cover property (pa_if.en && pa_duty == '0);

endmodule
